//--- adcr_pkg.sv
// Shared constants for the converter control and result register block
package adcr_pkg;
  // Register byte offsets on APB
  localparam logic [3:0] OFS_CTRL_MAIN  = 4'h0;
  localparam logic [3:0] OFS_CTRL_SRC   = 4'h4;
  localparam logic [3:0] OFS_RES_HIGH   = 4'h8;
  localparam logic [3:0] OFS_RES_LOW    = 4'hC;
  // Field positions of the main control register
  localparam int BIT_START     = 7;
  localparam int BIT_BUSY      = 6;
  localparam int BIT_ENABLE    = 5;
  localparam int BIT_ALIGN     = 4;
  localparam int CHAN_LSB      = 0;
  // Field positions of the source and clock register
  localparam int SRC_LSB       = 5;
  localparam int REF_LSB       = 3;
  localparam int DIV_LSB       = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_CTRL_SRC  = 8'h00;
  localparam logic [7:0] RST_RESULT    = 8'h00;
  // Conversion timing in converter clock cycles
  localparam int SAMPLE_TICKS  = 4;
  localparam int CONVERT_TICKS = 12;
  localparam logic [3:0] LAST_TICK = 4'(SAMPLE_TICKS + CONVERT_TICKS - 1);
  localparam logic [3:0] SAMPLE_END = 4'(SAMPLE_TICKS);
  // Select codes
  localparam logic [2:0] SRC_INTERNAL = 3'h1;
  localparam logic [2:0] SRC_GND_LO   = 3'h2;
  localparam logic [2:0] SRC_GND_HI   = 3'h4;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;
  localparam int EXT_CHANNELS  = 3;
endpackage

//--- adcr_top.sv
// Converter control registers, conversion sequencer and result registers on APB
`timescale 1ns/1ns
`default_nettype none
module adcr_top
  import adcr_pkg::*;
#(
  parameter int DIV_BITS = 7
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [11:0]             conv_result_in,
  input  wire logic [EXT_CHANNELS-1:0] pin_function_select_reg,
  output logic                         conv_power_on,
  output logic                         conv_sampling,
  output logic                         conv_clock_tick,
  output logic                         conv_done_irq,
  output logic [EXT_CHANNELS-1:0]      ext_analog_inputs,
  output logic                         internal_divider_voltage,
  output logic                         input_grounded,
  output logic                         converter_supply,
  output logic [EXT_CHANNELS-1:0]      pin_pullup_disable,
  output logic [EXT_CHANNELS-1:0]      pin_dir_override
);
  import adcr_pkg::*;

  typedef enum logic [0:0] {
    ADCR_IDLE = 1'b0,
    ADCR_RUN  = 1'b1
  } adcr_state_t;

  logic [7:0]          main_reg, main_next;
  logic [7:0]          src_reg, src_next;
  logic [7:0]          res_hi_reg, res_hi_next;
  logic [7:0]          res_lo_reg, res_lo_next;
  logic [31:0]         prdata_reg, prdata_next;
  logic                pready_reg, pready_next;
  logic                pslverr_reg, pslverr_next;
  adcr_state_t         state_reg, state_next;
  logic [DIV_BITS-1:0] div_reg, div_next;
  logic [3:0]          tick_cnt_reg, tick_cnt_next;
  logic                tick_reg, tick_next;
  logic                done_reg, done_next;
  logic                samp_reg, samp_next;
  logic [EXT_CHANNELS-1:0] chan_reg, chan_next;
  logic                int_reg, int_next, gnd_reg, gnd_next, sup_reg, sup_next;
  logic [EXT_CHANNELS-1:0] pin_reg;

  logic                wr_fire, mapped, start_seen, div_hit, en;
  logic [2:0]          src_sel;
  logic [DIV_BITS-1:0] div_top;

  assign en      = main_reg[BIT_ENABLE];
  assign src_sel = src_reg[SRC_LSB +: 3];
  assign wr_fire = psel & penable & pready_reg & pwrite;
  assign mapped  = (paddr[3:0] == OFS_CTRL_MAIN) | (paddr[3:0] == OFS_CTRL_SRC) |
                   (paddr[3:0] == OFS_RES_HIGH) | (paddr[3:0] == OFS_RES_LOW);
  // Start is a write that clears the stored start bit after it was set;
  // taken from the write itself so busy does not loop back through main_next
  assign start_seen = wr_fire && (paddr[3:0] == OFS_CTRL_MAIN) &&
                      main_reg[BIT_START] && !pwdata[BIT_START];
  // Divide ratio is a power of two picked by the clock select field
  assign div_top = DIV_BITS'((1 << src_reg[DIV_LSB +: 3]) - 1);
  assign div_hit = (div_reg == div_top);

  // APB slave: one wait state, so read data is a registered mux
  always_comb begin
    main_next    = main_reg;
    src_next     = src_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = psel & penable & ~pready_reg;
    if (psel & penable & ~pready_reg) begin
      pslverr_next = ~mapped;
      prdata_next  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr[3:0])
          OFS_CTRL_MAIN: prdata_next[7:0] = main_reg;
          OFS_CTRL_SRC:  prdata_next[7:0] = src_reg;
          OFS_RES_HIGH:  prdata_next[7:0] = res_hi_reg;
          OFS_RES_LOW:   prdata_next[7:0] = res_lo_reg;
          default:       prdata_next      = 32'h0000_0000;
        endcase
      end
    end
    if (wr_fire && paddr[3:0] == OFS_CTRL_MAIN) begin
      main_next = pwdata[7:0];
      main_next[BIT_BUSY] = main_reg[BIT_BUSY]; // Busy is read-only
    end
    if (wr_fire && paddr[3:0] == OFS_CTRL_SRC) begin
      src_next = pwdata[7:0];
    end
    // Busy follows the sequencer state
    main_next[BIT_BUSY] = (state_next == ADCR_RUN);
  end

  // Conversion sequencer; disabling aborts without touching the results
  always_comb begin
    state_next    = state_reg;
    div_next      = div_reg;
    tick_cnt_next = tick_cnt_reg;
    tick_next     = 1'b0;
    done_next     = 1'b0;
    res_hi_next   = res_hi_reg;
    res_lo_next   = res_lo_reg;
    unique case (state_reg)
      ADCR_IDLE: begin
        // A disabled converter ignores the start sequence
        if (start_seen && en) begin
          state_next    = ADCR_RUN;
          div_next      = '0;
          tick_cnt_next = 4'h0;
        end
      end
      ADCR_RUN: begin
        div_next = div_hit ? '0 : DIV_BITS'(div_reg + 1'b1);
        if (!en) begin
          state_next = ADCR_IDLE; // Power-off aborts, results kept
        end else if (div_hit) begin
          tick_next     = 1'b1;
          tick_cnt_next = 4'(tick_cnt_reg + 1'b1);
          if (tick_cnt_reg == LAST_TICK) begin
            state_next = ADCR_IDLE;
            done_next  = 1'b1; // Request raised with busy clear
            // Format fixed at completion
            if (main_reg[BIT_ALIGN]) begin
              res_hi_next = {4'h0, conv_result_in[11:8]};
              res_lo_next = conv_result_in[7:0];
            end else begin
              res_hi_next = conv_result_in[11:4];
              res_lo_next = {conv_result_in[3:0], 4'h0};
            end
          end
        end
      end
    endcase
  end

  // Analog select decode, registered so the pins never glitch
  always_comb begin
    samp_next = (state_next == ADCR_RUN) && (tick_cnt_next < SAMPLE_END);
    sup_next  = (src_reg[REF_LSB +: 2] == REF_SUPPLY);
    int_next  = (src_sel == SRC_INTERNAL);
    gnd_next  = (src_sel >= SRC_GND_LO) && (src_sel <= SRC_GND_HI);
    chan_next = '0;
    // Channel switches open unless source is external; codes above 2 float
    if (!int_next && !gnd_next) begin
      for (int i = 0; i < EXT_CHANNELS; i++) begin
        chan_next[i] = (main_reg[CHAN_LSB +: 4] == 4'(i));
      end
    end
  end

  // All state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_reg     <= RST_CTRL_MAIN;
      src_reg      <= RST_CTRL_SRC;
      res_hi_reg   <= RST_RESULT;
      res_lo_reg   <= RST_RESULT;
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      state_reg    <= ADCR_IDLE;
      div_reg      <= '0;
      tick_cnt_reg <= 4'h0;
      tick_reg     <= 1'b0;
      done_reg     <= 1'b0;
      samp_reg     <= 1'b0;
      chan_reg     <= '0;
      int_reg      <= 1'b0;
      gnd_reg      <= 1'b0;
      sup_reg      <= 1'b0;
      pin_reg      <= '0;
    end else begin
      main_reg     <= main_next;
      src_reg      <= src_next;
      res_hi_reg   <= res_hi_next;
      res_lo_reg   <= res_lo_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      state_reg    <= state_next;
      div_reg      <= div_next;
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
      done_reg     <= done_next;
      samp_reg     <= samp_next;
      chan_reg     <= chan_next;
      int_reg      <= int_next;
      gnd_reg      <= gnd_next;
      sup_reg      <= sup_next;
      pin_reg      <= pin_function_select_reg; // Pull-up off, direction forced
    end
  end

  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign conv_power_on            = main_reg[BIT_ENABLE];
  assign conv_sampling            = samp_reg;
  assign conv_clock_tick          = tick_reg;
  assign conv_done_irq            = done_reg;
  assign ext_analog_inputs        = chan_reg;
  assign internal_divider_voltage = int_reg;
  assign input_grounded           = gnd_reg;
  assign converter_supply         = sup_reg;
  assign pin_pullup_disable       = pin_reg;
  assign pin_dir_override         = pin_reg;

  // Checks on the sequencer and decode
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_busy: assert property (
    (state_reg == ADCR_IDLE && start_seen && en) |=> main_reg[BIT_BUSY])
    else $error("busy did not rise after start");
  a_disabled_idle: assert property (
    (!en && state_reg == ADCR_IDLE) |=> !main_reg[BIT_BUSY])
    else $error("conversion started while disabled");
  a_irq_on_clear: assert property (
    (done_reg) |-> ($fell(main_reg[BIT_BUSY]) && $past(en)))
    else $error("request not aligned with busy clear");
  a_conv_length: assert property (
    done_next |-> (tick_cnt_reg == 4'hF) && tick_next)
    else $error("conversion not sixteen ticks");
  a_result_hold: assert property (
    !done_reg |-> ($stable(res_hi_reg) && $stable(res_lo_reg)))
    else $error("result changed outside completion");
  a_left_zero: assert property (
    (done_next && !main_reg[BIT_ALIGN]) |=> res_lo_reg[3:0] == 4'h0)
    else $error("left aligned low nibble not zero");
  a_right_zero: assert property (
    (done_next && main_reg[BIT_ALIGN]) |=> res_hi_reg[7:4] == 4'h0)
    else $error("right aligned high nibble not zero");
  a_chan_float: assert property (
    (main_reg[3:0] > 4'h2) |=> ext_analog_inputs == '0)
    else $error("channel connected for floating code");
  a_src_decode: assert property (
    ##1 (internal_divider_voltage == ($past(src_sel) == SRC_INTERNAL)) &&
        (converter_supply == ($past(src_reg[4:3]) == REF_SUPPLY)))
    else $error("source or reference decode wrong");
  a_div_rate: assert property (
    (state_reg == ADCR_RUN && en && src_reg[2:0] == 3'h1 && tick_reg) |=> !tick_reg)
    else $error("divide by two ticks too fast");
  a_busy_ro: assert property (
    (state_reg == ADCR_IDLE && !start_seen) |=> !main_reg[BIT_BUSY])
    else $error("busy set by a write");
  a_ctrl_write: assert property (
    (wr_fire && paddr[3:0] == OFS_CTRL_SRC) |=> src_reg == $past(pwdata[7:0]))
    else $error("source register did not take the write");
  a_abort_quiet: assert property (
    (state_reg == ADCR_RUN && !en) |=> (!main_reg[BIT_BUSY] && !done_reg))
    else $error("disabled conversion still busy or completed");
  a_sample_busy: assert property (
    conv_sampling |-> main_reg[BIT_BUSY])
    else $error("sampling outside a conversion");
  a_gnd_decode: assert property (
    ##1 input_grounded == (($past(src_sel) >= SRC_GND_LO) && ($past(src_sel) <= SRC_GND_HI)))
    else $error("ground decode wrong");
  a_pin_follow: assert property (
    ##1 (pin_pullup_disable == $past(pin_function_select_reg)) &&
        (pin_dir_override == $past(pin_function_select_reg)))
    else $error("pin override does not follow the function select");
  // Bus side: exactly one wait state before the answer
  a_apb_wait: assert property (
    (psel && penable && !pready_reg) |=> pready_reg)
    else $error("no ready after the first access cycle");

  c_conversion: cover property (done_reg && main_reg[BIT_ALIGN]);
  c_left: cover property (done_reg && !main_reg[BIT_ALIGN]);
  c_abort: cover property (state_reg == ADCR_RUN && !en);
  c_slverr: cover property (pready_reg && pslverr_reg);
  c_internal: cover property (internal_divider_voltage && conv_sampling);
endmodule
`default_nettype wire

//--- adcr_analog_model.sv
// Behavioural analog front end that answers with a raw result per source
`timescale 1ns/1ns
`default_nettype none
module adcr_analog_model #(
  parameter logic [11:0] CH0_VAL = 12'h9A3,
  parameter logic [11:0] CH1_VAL = 12'h5C6,
  parameter logic [11:0] CH2_VAL = 12'hE1F,
  parameter logic [11:0] INT_VAL = 12'h7B4
) (
  input  wire logic       pclk,
  input  wire logic [2:0] ext_analog_inputs,
  input  wire logic       internal_divider_voltage,
  input  wire logic       input_grounded,
  output logic [11:0]     conv_result_in
);
  logic [11:0] float_reg = 12'h5A5;
  // A floating input has no level, so the value moves every cycle
  always @(posedge pclk) float_reg <= float_reg + 12'h3C7;
  // Switch matrix: ground wins, then the divider, then one external pin
  always_comb begin
    if (input_grounded) conv_result_in = 12'h000;
    else if (internal_divider_voltage) conv_result_in = INT_VAL;
    else if (ext_analog_inputs == 3'h1) conv_result_in = CH0_VAL;
    else if (ext_analog_inputs == 3'h2) conv_result_in = CH1_VAL;
    else if (ext_analog_inputs == 3'h4) conv_result_in = CH2_VAL;
    else conv_result_in = float_reg;
  end
endmodule
`default_nettype wire

//--- test_adc_control_result_regs.sv
// Self-checking bench for the converter control and result registers
`timescale 1ns/1ns
`default_nettype none
module test_adc_control_result_regs;
  import adcr_pkg::*;
  localparam logic [3:0][11:0] vals = {12'h7B4, 12'hE1F, 12'h5C6, 12'h9A3};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, conv_power_on, conv_sampling, conv_clock_tick;
  logic        conv_done_irq, internal_divider_voltage, input_grounded, converter_supply;
  logic [11:0] conv_result_in;
  logic [2:0]  pin_function_select_reg = '0, ext_analog_inputs, pin_pullup_disable;
  logic [2:0]  pin_dir_override;
  logic [15:0] prev = '0;
  int mismatches = 0, comparisons = 0, cyc = 0, ticks = 0, samps = 0, dones = 0, last = 0;
  int gap = 0;

  adcr_top #(.DIV_BITS(7)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_result_in, .pin_function_select_reg,
    .conv_power_on, .conv_sampling, .conv_clock_tick, .conv_done_irq, .ext_analog_inputs,
    .internal_divider_voltage, .input_grounded, .converter_supply, .pin_pullup_disable,
    .pin_dir_override);
  adcr_analog_model #(.CH0_VAL(vals[0]), .CH1_VAL(vals[1]), .CH2_VAL(vals[2]),
    .INT_VAL(vals[3])) model_u (.pclk, .ext_analog_inputs, .internal_divider_voltage,
    .input_grounded, .conv_result_in);

  always #2 pclk = ~pclk;

  // Monitor counts converter ticks, sampling cycles and completions; also the run limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conv_clock_tick === 1'b1) begin
      ticks <= ticks + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (conv_sampling === 1'b1) samps <= samps + 1;
    if (conv_done_irq === 1'b1) dones <= dones + 1;
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [3:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {28'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  task automatic t_access;
    rchk("main_rst", OFS_CTRL_MAIN, RST_CTRL_MAIN);
    rchk("src_rst", OFS_CTRL_SRC, RST_CTRL_SRC);
    apb(1'b1, OFS_CTRL_SRC, 8'hFF);
    rchk("src_rw", OFS_CTRL_SRC, 8'hFF);
    apb(1'b1, OFS_CTRL_MAIN, 8'h4F);
    rchk("busy_ro", OFS_CTRL_MAIN, 8'h0F);
    apb(1'b1, OFS_RES_HIGH, 8'hFF);
    rchk("res_ro", OFS_RES_HIGH, RST_RESULT);
    apb(1'b0, 4'h2, 8'h00);
    chk("slverr", 32'h1, {31'h0, err});
    pin_function_select_reg <= 3'h5;
    repeat (2) @(posedge pclk);
    chk("pullup", 32'h5, {29'h0, pin_pullup_disable});
    chk("dir", 32'h5, {29'h0, pin_dir_override});
    $display("test access done");
  endtask

  task automatic t_mux;
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 5; c++) begin
        if (s == 1 && c < 3) continue;
        // Supply reference is chosen when c[1:0] is 1, with the pin function select left at 5
        apb(1'b1, OFS_CTRL_SRC, {s[2:0], c[1:0], 3'h0});
        apb(1'b1, OFS_CTRL_MAIN, {4'h0, c[3:0]});
        @(posedge pclk);
        chk("ext", ((s == 0 || s > 4) && c < 3) ? 32'(1 << c) : 0, 32'(ext_analog_inputs));
        chk("int", 32'(s == 1), 32'(internal_divider_voltage));
        chk("gnd", 32'(s > 1 && s < 5), 32'(input_grounded));
        chk("ref", 32'(c[1:0] == 2'h1), 32'(converter_supply));
      end
    end
    $display("test mux done");
  endtask

  task automatic t_conv;
    int src [8] = '{0, 0, 0, 0, 0, 1, 3, 6};
    int ch [8] = '{0, 1, 2, 0, 1, 3, 0, 2};
    int t0, s0, d0;
    logic [15:0] f;
    for (int i = 0; i < 8; i++) begin
      f = (src[i] == 1) ? {4'h0, vals[3]} : (src[i] == 3) ? 16'h0 : {4'h0, vals[ch[i]]};
      f = i[0] ? f : {f[11:0], 4'h0};
      apb(1'b1, OFS_CTRL_SRC, {src[i][2:0], 2'h0, i[2:0]});
      apb(1'b1, OFS_CTRL_MAIN, {3'h5, i[0], ch[i][3:0]});
      t0 = ticks;
      s0 = samps;
      d0 = dones;
      apb(1'b1, OFS_CTRL_MAIN, {3'h1, i[0], ch[i][3:0]});
      rchk("busy_set", OFS_CTRL_MAIN, {3'h3, i[0], ch[i][3:0]});
      rchk("hold_hi", OFS_RES_HIGH, prev[15:8]);
      chk("power", 32'h1, 32'(conv_power_on));
      while (conv_done_irq !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      chk("ticks", 32'd16, 32'(ticks - t0));
      chk("sampling", 32'(4 << i), 32'(samps - s0));
      chk("divider", 32'(1 << i), 32'(gap));
      chk("irq", 32'd1, 32'(dones - d0));
      rchk("busy_clr", OFS_CTRL_MAIN, {3'h1, i[0], ch[i][3:0]});
      rchk("res_hi", OFS_RES_HIGH, f[15:8]);
      rchk("res_lo", OFS_RES_LOW, f[7:0]);
      prev = f;
    end
    $display("test conversion done");
  endtask

  task automatic t_off;
    int d0;
    d0 = dones;
    apb(1'b1, OFS_CTRL_SRC, 8'h07);
    apb(1'b1, OFS_CTRL_MAIN, 8'h80);
    apb(1'b1, OFS_CTRL_MAIN, 8'h00);
    repeat (40) @(posedge pclk);
    rchk("no_start", OFS_CTRL_MAIN, 8'h00);
    chk("power_off", 32'h0, 32'(conv_power_on));
    apb(1'b1, OFS_CTRL_MAIN, 8'hA0);
    apb(1'b1, OFS_CTRL_MAIN, 8'h20);
    repeat (20) @(posedge pclk);
    apb(1'b1, OFS_CTRL_MAIN, 8'h00);
    rchk("abort", OFS_CTRL_MAIN, 8'h00);
    repeat (2100) @(posedge pclk);
    chk("no_irq", 32'(d0), 32'(dones));
    rchk("kept_hi", OFS_RES_HIGH, prev[15:8]);
    rchk("kept_lo", OFS_RES_LOW, prev[7:0]);
    $display("test disable done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset held two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_access();
    t_mux();
    t_conv();
    t_off();
    summarize();
  end
endmodule
`default_nettype wire
